// ---- clock_net_pkg.sv ----
package clock_net_pkg;
    localparam int NUM_GLOBAL    = 16;
    localparam int NUM_REGIONAL  = 32;
    localparam int REG_PER_QUAD  = 8;
    localparam int QUAD_RES      = 24;
    localparam int NUM_CLK_PIN   = 16;
    localparam int PINS_PER_SIDE = 4;
    localparam int NUM_EXT       = 4;
    localparam int PLL_COUNTERS  = 6;
    localparam int ROW_CLKS      = 6;
    localparam int GRP_CLKS      = 3;
    localparam int IO_CLKS       = 8;
    localparam int GLB_INPUTS    = 5;
    localparam int REG_INPUTS    = 7;
    localparam int NUM_CELLS     = NUM_GLOBAL + NUM_REGIONAL + NUM_EXT;
    localparam int GLB_BASE      = 0;
    localparam int REG_BASE      = GLB_BASE + NUM_GLOBAL;
    localparam int EXT_BASE      = REG_BASE + NUM_REGIONAL;
    localparam int NUM_ROUTE     = ROW_CLKS + GRP_CLKS + IO_CLKS;
    localparam int ROUTE_ROW     = 0;
    localparam int ROUTE_GRP     = ROUTE_ROW + ROW_CLKS;
    localparam int ROUTE_IO      = ROUTE_GRP + GRP_CLKS;
    localparam int DUAL_STRIDE   = REG_PER_QUAD;

    localparam int SEL_W   = 3;
    localparam int DSEL_W  = 2;
    localparam int ROUTE_W = 5;
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 8;

    // per-cell configuration word layout
    localparam int CFG_SEL_LSB  = 0;
    localparam int CFG_SEL_MSB  = 2;
    localparam int CFG_DYN_MODE = 3;
    localparam int CFG_ON       = 4;
    localparam int CFG_CORNER   = 5;
    localparam int CFG_IO_MUX   = 6;
    localparam int CFG_PAIR     = 7;
    localparam logic [DATA_W-1:0]  CFG_RESET   = 8'h00;
    localparam logic [ROUTE_W-1:0] ROUTE_RESET = 5'h00;

    localparam logic [ADDR_W-1:0] CFG_ADDR_END  = 8'h34;
    localparam logic [ADDR_W-1:0] ROUTE_ADDR    = 8'h40;
    localparam logic [ADDR_W-1:0] ROUTE_ADDR_END = 8'h51;
    localparam logic [ADDR_W-1:0] STAT_ADDR     = 8'h80;
    localparam logic [ADDR_W-1:0] STAT_ADDR_END = 8'hB4;
endpackage : clock_net_pkg

// ---- clock_control_cell.sv ----
`timescale 1ns/100ps
module clock_control_cell
    import clock_net_pkg::*;
#(
    parameter int   N_IN = 5,
    parameter bit   DYN  = 1'b0
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // sources, sampled as levels
    input  wire logic [N_IN-1:0]         src_in,
    // static configuration
    input  wire logic [SEL_W-1:0]        static_sel,
    input  wire logic                    dyn_mode,
    input  wire logic                    corner,
    input  wire logic                    static_on,
    // fabric controls
    input  wire logic [DSEL_W-1:0]       dyn_sel,
    input  wire logic                    dyn_en,
    // network
    output logic                         net_o,
    output logic                         en_o
);
    logic [SEL_W-1:0] sel_r;
    logic [SEL_W-1:0] sel_nxt;
    logic             en_r;
    logic             net_r;
    logic [7:0]       src_pad;
    logic             src;
    logic             dyn_active;

    assign dyn_active = DYN && dyn_mode;
    assign src_pad    = 8'(src_in);
    assign src        = src_pad[sel_r];
    assign net_o      = net_r;
    assign en_o       = en_r;

    // dynamic select reaches only inputs 0..3 (pins and PLLs); logic input 4 is static-only
    always_comb begin
        sel_nxt = static_sel;
        if (dyn_active) begin
            if (corner && dyn_sel[1]) begin
                sel_nxt = sel_r;
            end else begin
                sel_nxt = {1'b0, dyn_sel};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_r <= 3'h0;
        end else begin
            sel_r <= sel_nxt;
        end
    end

    // enable is only retimed while the source is low, so a high phase is never cut short
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= 1'b0;
        end else if (!src) begin
            en_r <= static_on & dyn_en;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            net_r <= 1'b0;
        end else begin
            net_r <= src & en_r;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_off_settled;
        (!static_on && !src) ##1 (!static_on) [*2];
    endsequence

    AST_EN_ONLY_LOW: assert property ($changed(en_r) |-> !$past(src))
        else $error("enable changed while source was high");
    AST_OFF_STAYS_LOW: assert property (s_off_settled |-> !net_r)
        else $error("network pulsed while statically off");
    AST_STATIC_FOLLOWS: assert property (!dyn_active ##1 !dyn_active |-> sel_r == $past(static_sel))
        else $error("static select not applied");
    AST_CORNER_BLOCK: assert property (dyn_active && corner && dyn_sel[1] |=> $stable(sel_r))
        else $error("corner PLL input taken dynamically");
    AST_DYN_RANGE: assert property (dyn_active && !corner |=> sel_r == {1'b0, $past(dyn_sel)})
        else $error("dynamic select outside pin and PLL inputs");
    AST_NET_TRACKS: assert property (en_r ##1 en_r |-> net_r == $past(src))
        else $error("enabled network does not follow source");
endmodule : clock_control_cell

// ---- clock_network_select_gate.sv ----
// The address map and strobed register access were decided locally.
`timescale 1ns/100ps
module clock_network_select_gate
    import clock_net_pkg::*;
(
    // clock and reset
    input  wire logic                                    MCLK,
    input  wire logic                                    RST_B,
    // register port
    input  wire logic [clock_net_pkg::ADDR_W-1:0]        ADDR,
    input  wire logic [clock_net_pkg::DATA_W-1:0]        WDATA,
    input  wire logic                                    WR_STB,
    input  wire logic                                    RD_STB,
    output logic      [clock_net_pkg::DATA_W-1:0]        RDATA,
    // clock sources
    input  wire logic [clock_net_pkg::NUM_CLK_PIN-1:0]   CLK_PIN,
    input  wire logic [2*clock_net_pkg::NUM_GLOBAL-1:0]  GLB_PLL_CLK,
    input  wire logic [clock_net_pkg::NUM_GLOBAL-1:0]    GLB_LOGIC_CLK,
    input  wire logic [2*clock_net_pkg::NUM_REGIONAL-1:0] REG_PLL_CLK,
    input  wire logic [clock_net_pkg::NUM_REGIONAL-1:0]  REG_LOGIC_CLK,
    input  wire logic [clock_net_pkg::PLL_COUNTERS*clock_net_pkg::NUM_EXT-1:0] EXT_PLL_C,
    input  wire logic [clock_net_pkg::NUM_EXT-1:0]       EXT_IO_DATA,
    // fabric controls
    input  wire logic [2*clock_net_pkg::NUM_GLOBAL-1:0]  GLB_DYN_SEL,
    input  wire logic [clock_net_pkg::NUM_GLOBAL-1:0]    GLB_DYN_EN,
    input  wire logic [clock_net_pkg::NUM_REGIONAL-1:0]  REG_DYN_EN,
    input  wire logic [clock_net_pkg::NUM_EXT-1:0]       EXT_DYN_EN,
    // networks
    output logic      [clock_net_pkg::NUM_GLOBAL-1:0]    GLOBAL_CLOCK_NET,
    output logic      [clock_net_pkg::NUM_REGIONAL-1:0]  REGIONAL_CLOCK_NET,
    output logic      [clock_net_pkg::NUM_EXT-1:0]       PLL_OUT_PIN,
    output logic      [clock_net_pkg::GRP_CLKS-1:0]      GROUP_CLK,
    output logic      [clock_net_pkg::IO_CLKS-1:0]       IO_CLK
);
    import clock_net_pkg::*;

    logic                   rst_s1;
    logic                   rst_n;
    logic [DATA_W-1:0]      cfg_r   [NUM_CELLS];
    logic [ROUTE_W-1:0]     route_r [NUM_ROUTE];
    logic [DATA_W-1:0]      rdata_r;
    logic [NUM_CELLS-1:0]   cell_net;
    logic [NUM_CELLS-1:0]   cell_en;
    logic [NUM_REGIONAL-1:0] reg_net_r;
    logic [NUM_REGIONAL-1:0] reg_nxt;
    logic [NUM_EXT-1:0]     pin_r;
    logic [ROW_CLKS-1:0]    row_r;
    logic [GRP_CLKS-1:0]    grp_r;
    logic [IO_CLKS-1:0]     io_r;
    logic [QUAD_RES-1:0]    quad_res;
    logic [31:0]            quad_pad;
    logic [7:0]             row_pad;
    logic [ADDR_W-1:0]      route_off;

    // release of the external reset is retimed; only the second stage is used
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    assign route_off = ADDR - ROUTE_ADDR;

    // configuration image clears to all-off, so unused global and regional networks stay powered down; external cells are tied on
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CELLS; i++) begin
                cfg_r[i] <= CFG_RESET;
            end
        end else if (WR_STB && ADDR < CFG_ADDR_END) begin
            cfg_r[ADDR[5:0]] <= WDATA;
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_ROUTE; i++) begin
                route_r[i] <= ROUTE_RESET;
            end
        end else if (WR_STB && ADDR >= ROUTE_ADDR && ADDR < ROUTE_ADDR_END) begin
            route_r[route_off[4:0]] <= WDATA[ROUTE_W-1:0];
        end
    end

    // unmapped reads answer zero; a read never stalls
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (RD_STB) begin
            if (ADDR < CFG_ADDR_END) begin
                rdata_r <= cfg_r[ADDR[5:0]];
            end else if (ADDR >= ROUTE_ADDR && ADDR < ROUTE_ADDR_END) begin
                rdata_r <= {3'h0, route_r[route_off[4:0]]};
            end else if (ADDR >= STAT_ADDR && ADDR < STAT_ADDR_END) begin
                rdata_r <= {6'h00, cell_en[ADDR[5:0]], cell_net[ADDR[5:0]]};
            end else begin
                rdata_r <= 8'h00;
            end
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign RDATA = rdata_r;

    // global cells: even pin on input 0, odd pin on input 1, two PLL taps, then fabric logic
    generate
        for (genvar g = 0; g < NUM_GLOBAL; g++) begin : gen_global
            clock_control_cell #(
                .N_IN (GLB_INPUTS),
                .DYN  (1'b1)
            ) u_cell (
                .clk        (MCLK),
                .rst_n      (rst_n),
                .src_in     ({GLB_LOGIC_CLK[g], GLB_PLL_CLK[2*g+1], GLB_PLL_CLK[2*g],
                              CLK_PIN[2*(g%8)+1], CLK_PIN[2*(g%8)]}),
                .static_sel (cfg_r[GLB_BASE+g][CFG_SEL_MSB:CFG_SEL_LSB]),
                .dyn_mode   (cfg_r[GLB_BASE+g][CFG_DYN_MODE]),
                .corner     (cfg_r[GLB_BASE+g][CFG_CORNER]),
                .static_on  (cfg_r[GLB_BASE+g][CFG_ON]),
                .dyn_sel    (GLB_DYN_SEL[2*g +: 2]),
                .dyn_en     (GLB_DYN_EN[g]),
                .net_o      (cell_net[GLB_BASE+g]),
                .en_o       (cell_en[GLB_BASE+g])
            );
        end

        // regional cells draw on the four pins of their own side
        for (genvar r = 0; r < NUM_REGIONAL; r++) begin : gen_regional
            localparam int Q = r / REG_PER_QUAD;
            localparam int P = r ^ DUAL_STRIDE;
            clock_control_cell #(
                .N_IN (REG_INPUTS),
                .DYN  (1'b0)
            ) u_cell (
                .clk        (MCLK),
                .rst_n      (rst_n),
                .src_in     ({REG_LOGIC_CLK[r], REG_PLL_CLK[2*r+1], REG_PLL_CLK[2*r],
                              CLK_PIN[PINS_PER_SIDE*Q +: PINS_PER_SIDE]}),
                .static_sel (cfg_r[REG_BASE+r][CFG_SEL_MSB:CFG_SEL_LSB]),
                .dyn_mode   (1'b0),
                .corner     (cfg_r[REG_BASE+r][CFG_CORNER]),
                .static_on  (cfg_r[REG_BASE+r][CFG_ON]),
                .dyn_sel    (2'h0),
                .dyn_en     (REG_DYN_EN[r]),
                .net_o      (cell_net[REG_BASE+r]),
                .en_o       (cell_en[REG_BASE+r])
            );
            // a paired line carries the same-numbered line of the adjacent quadrant
            always_comb begin
                if (cfg_r[REG_BASE+r][CFG_PAIR]) begin
                    reg_nxt[r] = cell_net[REG_BASE+P] & ~cfg_r[REG_BASE+P][CFG_CORNER];
                end else begin
                    reg_nxt[r] = cell_net[REG_BASE+r];
                end
            end
        end

        for (genvar e = 0; e < NUM_EXT; e++) begin : gen_ext
            clock_control_cell #(
                .N_IN (PLL_COUNTERS),
                .DYN  (1'b0)
            ) u_cell (
                .clk        (MCLK),
                .rst_n      (rst_n),
                .src_in     (EXT_PLL_C[PLL_COUNTERS*e +: PLL_COUNTERS]),
                .static_sel (cfg_r[EXT_BASE+e][CFG_SEL_MSB:CFG_SEL_LSB]),
                .dyn_mode   (1'b0),
                .corner     (1'b0),
                .static_on  (1'b1),
                .dyn_sel    (2'h0),
                .dyn_en     (EXT_DYN_EN[e]),
                .net_o      (cell_net[EXT_BASE+e]),
                .en_o       (cell_en[EXT_BASE+e])
            );
        end
    endgenerate

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            reg_net_r <= '0;
        end else begin
            reg_net_r <= reg_nxt;
        end
    end

    // dual-purpose pin: ordinary fabric signal unless the cell output is chosen
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_r <= '0;
        end else begin
            for (int e = 0; e < NUM_EXT; e++) begin
                pin_r[e] <= cfg_r[EXT_BASE+e][CFG_IO_MUX] ? cell_net[EXT_BASE+e] : EXT_IO_DATA[e];
            end
        end
    end

    // first quadrant resources: eight regional lines then all sixteen globals
    assign quad_res = {cell_net[GLB_BASE +: NUM_GLOBAL], reg_net_r[0 +: REG_PER_QUAD]};
    assign quad_pad = 32'(quad_res);
    assign row_pad  = 8'(row_r);

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            row_r <= '0;
            io_r  <= '0;
        end else begin
            for (int k = 0; k < ROW_CLKS; k++) begin
                row_r[k] <= quad_pad[route_r[ROUTE_ROW+k]];
            end
            for (int k = 0; k < IO_CLKS; k++) begin
                io_r[k] <= quad_pad[route_r[ROUTE_IO+k]];
            end
        end
    end

    // only the low three index bits are decoded: 6 and 7 yield a quiet clock, higher indexes wrap onto the row clocks
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            grp_r <= '0;
        end else begin
            for (int k = 0; k < GRP_CLKS; k++) begin
                grp_r[k] <= row_pad[route_r[ROUTE_GRP+k][2:0]];
            end
        end
    end

    assign GLOBAL_CLOCK_NET   = cell_net[GLB_BASE +: NUM_GLOBAL];
    assign REGIONAL_CLOCK_NET = reg_net_r;
    assign PLL_OUT_PIN        = pin_r;
    assign GROUP_CLK          = grp_r;
    assign IO_CLK             = io_r;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!rst_n);

    sequence s_cfg_write;
        WR_STB && ADDR < CFG_ADDR_END;
    endsequence

    sequence s_same_read;
        RD_STB && !WR_STB && ADDR == $past(ADDR);
    endsequence

    AST_CFG_READBACK: assert property (s_cfg_write ##1 s_same_read |=> RDATA == $past(WDATA, 2))
        else $error("configuration word not read back");
    AST_UNMAPPED: assert property (RD_STB && ((ADDR >= CFG_ADDR_END && ADDR < ROUTE_ADDR)
                                   || (ADDR >= ROUTE_ADDR_END && ADDR < STAT_ADDR)) |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    AST_IO_MUX: assert property (cfg_r[EXT_BASE][CFG_IO_MUX] |=> PLL_OUT_PIN[0] == $past(cell_net[EXT_BASE]))
        else $error("pin mux did not forward cell output");
    AST_DUAL_CORNER: assert property (cfg_r[REG_BASE+DUAL_STRIDE][CFG_PAIR] && cfg_r[REG_BASE][CFG_CORNER]
                                      |=> !REGIONAL_CLOCK_NET[DUAL_STRIDE])
        else $error("corner source drove a dual-regional line");
endmodule : clock_network_select_gate

// ---- fabric_drive_model.sv ----
`timescale 1ns/100ps
module fabric_drive_model
    import clock_net_pkg::*;
(
    // clock
    input  wire logic                                   clk,
    // requests from the test sequence
    input  wire logic [2*clock_net_pkg::NUM_GLOBAL-1:0] sel_req,
    input  wire logic [clock_net_pkg::NUM_GLOBAL-1:0]   gen_req,
    input  wire logic [clock_net_pkg::NUM_REGIONAL-1:0] ren_req,
    input  wire logic [clock_net_pkg::NUM_EXT-1:0]      xen_req,
    // controls toward the cells
    output logic      [2*clock_net_pkg::NUM_GLOBAL-1:0] sel_o,
    output logic      [clock_net_pkg::NUM_GLOBAL-1:0]   gen_o,
    output logic      [clock_net_pkg::NUM_REGIONAL-1:0] ren_o,
    output logic      [clock_net_pkg::NUM_EXT-1:0]      xen_o
);
    // user flops launch controls off the system clock, one cycle late like real fabric
    always_ff @(posedge clk) begin
        sel_o <= sel_req; // select bit 0 picks the odd pin, or the odd PLL tap when bit 1 is also set
        gen_o <= gen_req;
        ren_o <= ren_req;
        xen_o <= xen_req; // runts are not filtered here; the bench samples settled levels
    end
endmodule : fabric_drive_model

// ---- clock_network_select_gate_tb_top.sv ----
`timescale 1ns/100ps
module clock_network_select_gate_tb_top;
    import clock_net_pkg::*;
    logic                            MCLK, RST_B, WR_STB, RD_STB;
    logic [ADDR_W-1:0]               ADDR;
    logic [DATA_W-1:0]               WDATA, RDATA;
    logic [NUM_CLK_PIN-1:0]          CLK_PIN;
    logic [2*NUM_GLOBAL-1:0]         GLB_PLL_CLK, GLB_DYN_SEL, sel_req;
    logic [NUM_GLOBAL-1:0]           GLB_LOGIC_CLK, GLB_DYN_EN, GLOBAL_CLOCK_NET, gen_req;
    logic [2*NUM_REGIONAL-1:0]       REG_PLL_CLK;
    logic [NUM_REGIONAL-1:0]         REG_LOGIC_CLK, REG_DYN_EN, REGIONAL_CLOCK_NET, ren_req;
    logic [PLL_COUNTERS*NUM_EXT-1:0] EXT_PLL_C;
    logic [NUM_EXT-1:0]              EXT_IO_DATA, EXT_DYN_EN, PLL_OUT_PIN, xen_req;
    logic [GRP_CLKS-1:0]             GROUP_CLK;
    logic [IO_CLKS-1:0]              IO_CLK;
    int                              fail_count, check_count;
    int gk[5] = '{0, 0, 1, 1, 2};
    int gi[5] = '{0, 1, 0, 1, 0};
    int rk[7] = '{0, 0, 0, 0, 3, 3, 4};
    int ri[7] = '{0, 1, 2, 3, 0, 1, 0};

    clock_network_select_gate i_dut (.MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
        .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .CLK_PIN(CLK_PIN),
        .GLB_PLL_CLK(GLB_PLL_CLK), .GLB_LOGIC_CLK(GLB_LOGIC_CLK), .REG_PLL_CLK(REG_PLL_CLK),
        .REG_LOGIC_CLK(REG_LOGIC_CLK), .EXT_PLL_C(EXT_PLL_C), .EXT_IO_DATA(EXT_IO_DATA),
        .GLB_DYN_SEL(GLB_DYN_SEL), .GLB_DYN_EN(GLB_DYN_EN), .REG_DYN_EN(REG_DYN_EN),
        .EXT_DYN_EN(EXT_DYN_EN), .GLOBAL_CLOCK_NET(GLOBAL_CLOCK_NET),
        .REGIONAL_CLOCK_NET(REGIONAL_CLOCK_NET), .PLL_OUT_PIN(PLL_OUT_PIN), .GROUP_CLK(GROUP_CLK),
        .IO_CLK(IO_CLK));

    fabric_drive_model i_fabric (.clk(MCLK), .sel_req(sel_req), .gen_req(gen_req),
        .ren_req(ren_req), .xen_req(xen_req), .sel_o(GLB_DYN_SEL), .gen_o(GLB_DYN_EN),
        .ren_o(REG_DYN_EN), .xen_o(EXT_DYN_EN));

    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk_byte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: read %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_net(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: net %b expected %b", $time, got, exp);
        end
    endtask : chk_net

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge MCLK);
        ADDR   <= a;
        WDATA  <= d;
        WR_STB <= 1'b1;
        @(posedge MCLK);
        WR_STB <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge MCLK);
        ADDR   <= a;
        RD_STB <= 1'b1;
        @(posedge MCLK);
        RD_STB <= 1'b0;
        #1;
        chk_byte(RDATA, exp);
    endtask : rd_chk

    // write and read back with no idle cycle between the strobes
    task automatic wr_rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge MCLK);
        ADDR   <= a;
        WDATA  <= d;
        WR_STB <= 1'b1;
        @(posedge MCLK);
        WR_STB <= 1'b0;
        RD_STB <= 1'b1;
        @(posedge MCLK);
        RD_STB <= 1'b0;
        #1;
        chk_byte(RDATA, d);
    endtask : wr_rd_chk

    task automatic set_src(input int k, input int i, input logic v);
        @(posedge MCLK);
        case (k)
            0: CLK_PIN[i] <= v;
            1: GLB_PLL_CLK[i] <= v;
            2: GLB_LOGIC_CLK[i] <= v;
            3: REG_PLL_CLK[i] <= v;
            4: REG_LOGIC_CLK[i] <= v;
            5: EXT_PLL_C[i] <= v;
            default: EXT_IO_DATA[i] <= v;
        endcase
    endtask : set_src

    function automatic logic net_of(input int o);
        case (o)
            0: return GLOBAL_CLOCK_NET[0];
            1: return REGIONAL_CLOCK_NET[0];
            2: return PLL_OUT_PIN[0];
            3: return GROUP_CLK[0];
            4: return IO_CLK[0];
            default: return REGIONAL_CLOCK_NET[8];
        endcase
    endfunction : net_of

    // source low first so a pending enable change can land
    task automatic follow(input int k, input int i, input int o, input logic exp);
        repeat (3) @(posedge MCLK);
        set_src(k, i, 1'b1);
        repeat (6) @(posedge MCLK);
        #1;
        chk_net(net_of(o), exp);
        set_src(k, i, 1'b0);
        repeat (6) @(posedge MCLK);
        #1;
        chk_net(net_of(o), 1'b0);
    endtask : follow

    initial begin
        #1_000_000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        {RST_B, WR_STB, RD_STB, ADDR, WDATA, CLK_PIN, GLB_PLL_CLK, GLB_LOGIC_CLK} = '0;
        {REG_PLL_CLK, REG_LOGIC_CLK, EXT_PLL_C, EXT_IO_DATA, sel_req} = '0;
        {gen_req, ren_req, xen_req} = '1;
        fail_count = 0;
        check_count = 0;
        repeat (10) @(posedge MCLK);
        RST_B <= 1'b1;
        repeat (3) @(posedge MCLK);
        rd_chk(8'h00, 8'h00);
        follow(0, 0, 0, 1'b0);
        wr_rd_chk(8'h05, 8'hA5);
        wr(8'h60, 8'h5A);
        rd_chk(8'h60, 8'h00);
        wr(8'h05, 8'h00);
        $display("test registers done");
        for (int s = 0; s < 5; s++) begin
            wr(8'h00, 8'h10 | s[7:0]);
            follow(gk[s], gi[s], 0, 1'b1);
            follow(gk[(s+1)%5], gi[(s+1)%5], 0, 1'b0);
        end
        $display("test global static done");
        wr(8'h00, 8'h18);
        for (int s = 0; s < 4; s++) begin
            @(posedge MCLK);
            sel_req[1:0] <= s[1:0];
            follow(gk[s], gi[s], 0, 1'b1);
            follow(2, 0, 0, 1'b0);
        end
        @(posedge MCLK);
        sel_req[1:0] <= 2'h0;
        repeat (3) @(posedge MCLK);
        wr(8'h00, 8'h38);
        @(posedge MCLK);
        sel_req[1:0] <= 2'h2;
        follow(1, 0, 0, 1'b0);
        follow(0, 0, 0, 1'b1);
        $display("test global dynamic done");
        wr(8'h00, 8'h10);
        set_src(0, 0, 1'b1);
        gen_req[0] <= 1'b0;
        repeat (5) @(posedge MCLK);
        #1;
        chk_net(GLOBAL_CLOCK_NET[0], 1'b1);
        set_src(0, 0, 1'b0);
        follow(0, 0, 0, 1'b0);
        gen_req[0] <= 1'b1;
        follow(0, 0, 0, 1'b1);
        rd_chk(8'h80, 8'h02);
        wr(8'h00, 8'h00);
        follow(0, 0, 0, 1'b0);
        $display("test gating done");
        for (int s = 0; s < 7; s++) begin
            wr(8'h10, 8'h18 | s[7:0]);
            follow(rk[s], ri[s], 1, 1'b1);
        end
        ren_req[0] <= 1'b0;
        follow(4, 0, 1, 1'b0);
        ren_req[0] <= 1'b1;
        wr(8'h10, 8'h10);
        wr(8'h18, 8'h90);
        follow(0, 0, 5, 1'b1);
        wr(8'h10, 8'h30);
        follow(0, 0, 5, 1'b0);
        $display("test regional done");
        for (int s = 0; s < 6; s++) begin
            wr(8'h30, 8'h40 | s[7:0]);
            follow(5, s, 2, 1'b1);
        end
        xen_req[0] <= 1'b0;
        follow(5, 5, 2, 1'b0);
        xen_req[0] <= 1'b1;
        wr(8'h30, 8'h00);
        follow(6, 0, 2, 1'b1);
        follow(5, 0, 2, 1'b0);
        $display("test external done");
        wr(8'h00, 8'h10);
        wr(8'h40, 8'h08);
        wr(8'h46, 8'h00);
        wr(8'h49, 8'h08);
        follow(0, 0, 3, 1'b1);
        follow(0, 0, 4, 1'b1);
        wr(8'h10, 8'h10);
        wr(8'h49, 8'h00);
        follow(0, 0, 4, 1'b1);
        $display("test routing done");
        tally_and_finish();
    end
endmodule : clock_network_select_gate_tb_top
